// File: rtl/dso_pkg.sv
// package: constants, register map and carriers of the synchronous termination control
// ************************************************************
// Behaviour
// - Synchronous termination runs only with the delay-locked loop on and locked and some termination enabled.
// - It runs with clock enable high or in active power-down, and in precharge power-down only when the loop stays on.
// - Termination turns on the turn-on latency after the input is first registered high.
// - Termination turns off the turn-off latency after the input is registered low.
// - Both latencies equal write latency minus two, write latency being cas write plus additive latency.
// - The internal termination request is delayed by the additive latency relative to the pin.
// - Hold windows run from high registration, or from write registration, to low registration.
// - Dynamic switching is enabled when either bit of the write termination field is one.
// - With dynamic switching, write strength is selected write latency minus two after a write.
// - Nominal strength returns turn-off latency plus six (eight beats) or plus four (chopped) after a write.
// ************************************************************
package dso_pkg;
  localparam logic [7:0] DSO_CFG_OFS = 8'h00;
  localparam logic [7:0] DSO_STAT_OFS = 8'h04;
  localparam logic [4:0] DSO_LAT_SUB = 5'h02;
  localparam logic [2:0] DSO_HOLD_SHORT = 3'h4;
  localparam logic [2:0] DSO_HOLD_LONG = 3'h6;
  localparam logic [4:0] DSO_CWL_RST = 5'h05;
  localparam logic [4:0] DSO_AL_RST = 5'h00;
  localparam logic [2:0] DSO_NOM_RST = 3'h0;
  localparam logic [1:0] DSO_WR_RST = 2'h0;
  // config word fields
  localparam int DSO_CWL_LSB = 0;
  localparam int DSO_AL_LSB = 8;
  localparam int DSO_NOM_LSB = 16;
  localparam int DSO_WR_LSB = 20;
  localparam int DSO_DLLPD_BIT = 24;
  localparam int DSO_DLLON_BIT = 25;
  // status word fields
  localparam int DSO_ST_TERM_BIT = 0;
  localparam int DSO_ST_WRSEL_BIT = 1;
  localparam int DSO_ST_SYNC_BIT = 2;
  localparam int DSO_ST_ERR_BIT = 3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dso_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dso_apb_rsp_t;

  typedef struct packed {
    logic dll_locked;
    logic cke;
    logic bank_open;
    logic wr_cmd;
    logic wr_chop;
  } dso_core_in_t;
endpackage : dso_pkg

// File: rtl/dso_term_ctrl.sv
// synchronous on-die termination timing with dynamic write strength and an apb register slave
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module dso_term_ctrl #(
  parameter int PIPE_D = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic term_req_pin,
  input wire dso_pkg::dso_core_in_t core_i,
  input wire dso_pkg::dso_apb_req_t apb_i,
  output dso_pkg::dso_apb_rsp_t apb_o,
  output logic term_en,
  output logic term_wr_sel
);
  import dso_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [PIPE_D-1:0] odt_pipe;
    logic [2:0] wr_al;
    logic [2:0] chop_al;
    logic [PIPE_D-1:0] wr_pipe;
    logic [PIPE_D-1:0] chop_pipe;
    logic term;
    logic wr_sel;
    logic sync;
    logic [2:0] hold_cnt;
    logic hold_err;
    logic [4:0] cas_write_latency;
    logic [4:0] al;
    logic [2:0] nom;
    logic [1:0] wrt;
    logic dll_pd_keep;
    logic dll_on;
    dso_apb_rsp_t rsp;
  } dso_state_t;

  dso_state_t st_q;
  dso_state_t st_d;
  logic [4:0] lat;
  logic nom_on;
  logic dyn_on;
  logic sync_ok;
  logic wr_now;
  logic chop_now;
  logic acc;
  logic hit_cfg;
  logic hit_stat;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;

  // ************************************************************
  // mode and latency
  // ************************************************************
  assign lat = st_q.cas_write_latency + st_q.al - DSO_LAT_SUB;
  assign nom_on = st_q.nom != 3'h0;
  assign dyn_on = st_q.wrt != 2'h0;
  // precharge power-down is clock enable low with no bank open
  assign sync_ok = core_i.dll_locked && st_q.dll_on && (nom_on || dyn_on)
    && (core_i.cke || core_i.bank_open || st_q.dll_pd_keep);
  // commands pass three stages so a write lands on the edge where the pin sampled with it counts
  assign wr_now = st_q.wr_al[2];
  assign chop_now = st_q.chop_al[2];

  assign acc = apb_i.psel && apb_i.penable && st_q.rsp.pready;
  assign hit_cfg = apb_i.paddr == DSO_CFG_OFS;
  assign hit_stat = apb_i.paddr == DSO_STAT_OFS;

  always_comb begin
    cfg_word = 32'h0;
    cfg_word[DSO_CWL_LSB +: 5] = st_q.cas_write_latency;
    cfg_word[DSO_AL_LSB +: 5] = st_q.al;
    cfg_word[DSO_NOM_LSB +: 3] = st_q.nom;
    cfg_word[DSO_WR_LSB +: 2] = st_q.wrt;
    cfg_word[DSO_DLLPD_BIT] = st_q.dll_pd_keep;
    cfg_word[DSO_DLLON_BIT] = st_q.dll_on;
    stat_word = 32'h0;
    stat_word[DSO_ST_TERM_BIT] = st_q.term;
    stat_word[DSO_ST_WRSEL_BIT] = st_q.wr_sel;
    stat_word[DSO_ST_SYNC_BIT] = st_q.sync;
    stat_word[DSO_ST_ERR_BIT] = st_q.hold_err;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    // pin: a change counts once the second and third stages agree
    st_d.s1 = term_req_pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s2;
    end
    st_d.wr_al = {st_q.wr_al[1:0], core_i.wr_cmd};
    st_d.chop_al = {st_q.chop_al[1:0], core_i.wr_chop};
    st_d.sync = sync_ok;

    // tap k of a pipe holds what was registered k+1 edges ago
    st_d.odt_pipe = {st_q.odt_pipe[PIPE_D-2:0], st_d.lvl};
    st_d.wr_pipe = {st_q.wr_pipe[PIPE_D-2:0], wr_now && dyn_on};
    st_d.chop_pipe = {st_q.chop_pipe[PIPE_D-2:0], chop_now};

    // clear first so a new write that lands on the same edge keeps write strength
    if (st_q.chop_pipe[lat+5'h3] && st_q.wr_pipe[lat+5'h3]) begin
      st_d.wr_sel = 1'b0;
    end
    if (!st_q.chop_pipe[lat+5'h5] && st_q.wr_pipe[lat+5'h5]) begin
      st_d.wr_sel = 1'b0;
    end
    if (st_q.wr_pipe[lat-5'h1]) begin
      st_d.wr_sel = 1'b1;
    end
    if (!sync_ok || !dyn_on) begin
      st_d.wr_sel = 1'b0;
    end
    // asynchronous mode is not modelled: outside sync mode termination is simply off
    st_d.term = sync_ok && ((st_q.odt_pipe[lat-5'h1] && nom_on) || st_d.wr_sel);

    // hold window watchdog on the controller's behaviour
    st_d.hold_cnt = (st_q.hold_cnt != 3'h0) ? st_q.hold_cnt - 3'h1 : 3'h0;
    if (st_d.lvl && !st_q.lvl) begin
      st_d.hold_cnt = DSO_HOLD_SHORT - 3'h1;
    end
    if (wr_now && st_d.lvl) begin
      // keep the later deadline
      if (chop_now && st_d.hold_cnt < DSO_HOLD_SHORT - 3'h1) begin
        st_d.hold_cnt = DSO_HOLD_SHORT - 3'h1;
      end
      if (!chop_now && st_d.hold_cnt < DSO_HOLD_LONG - 3'h1) begin
        st_d.hold_cnt = DSO_HOLD_LONG - 3'h1;
      end
    end

    // apb: ready comes one cycle into the access phase
    st_d.rsp.pready = apb_i.psel && apb_i.penable && !st_q.rsp.pready;
    st_d.rsp.pslverr = 1'b0;
    st_d.rsp.prdata = 32'h0;
    if (st_d.rsp.pready) begin
      st_d.rsp.pslverr = !(hit_cfg || hit_stat);
      if (!apb_i.pwrite && hit_cfg) begin
        st_d.rsp.prdata = cfg_word;
      end
      if (!apb_i.pwrite && hit_stat) begin
        st_d.rsp.prdata = stat_word;
      end
    end
    if (acc && apb_i.pwrite && hit_cfg) begin
      st_d.cas_write_latency = apb_i.pwdata[DSO_CWL_LSB +: 5];
      st_d.al = apb_i.pwdata[DSO_AL_LSB +: 5];
      st_d.nom = apb_i.pwdata[DSO_NOM_LSB +: 3];
      st_d.wrt = apb_i.pwdata[DSO_WR_LSB +: 2];
      st_d.dll_pd_keep = apb_i.pwdata[DSO_DLLPD_BIT];
      st_d.dll_on = apb_i.pwdata[DSO_DLLON_BIT];
    end
    if (acc && apb_i.pwrite && hit_stat && apb_i.pwdata[DSO_ST_ERR_BIT]) begin
      st_d.hold_err = 1'b0;
    end
    // a violation in the clearing cycle still sets the flag
    if (!st_d.lvl && st_q.lvl && st_q.hold_cnt != 3'h0) begin
      st_d.hold_err = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= '0;
      st_q.cas_write_latency <= DSO_CWL_RST;
      st_q.al <= DSO_AL_RST;
      st_q.nom <= DSO_NOM_RST;
      st_q.wrt <= DSO_WR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_o = st_q.rsp;
  assign term_en = st_q.term;
  assign term_wr_sel = st_q.wr_sel;

  // ************************************************************
  // checks
  // ************************************************************
  logic [5:0] age_hi;
  logic [5:0] age_lo;
  logic [5:0] age_wr;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      age_hi <= 6'h3F;
      age_lo <= 6'h3F;
      age_wr <= 6'h3F;
    end else begin
      age_hi <= (st_d.lvl && !st_q.lvl) ? 6'h0 : age_hi + {5'h0, age_hi != 6'h3F};
      age_lo <= (!st_d.lvl && st_q.lvl) ? 6'h0 : age_lo + {5'h0, age_lo != 6'h3F};
      age_wr <= (wr_now && dyn_on) ? 6'h0 : age_wr + {5'h0, age_wr != 6'h3F};
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence early_fall_s;
    st_q.lvl && st_q.hold_cnt != 3'h0 ##1 !st_q.lvl;
  endsequence

  sync_gate_a: assert property (!st_d.sync |=> !term_en) else $error("term on outside sync mode");
  pd_gate_a: assert property (
    !core_i.cke && !core_i.bank_open && !st_q.dll_pd_keep |=> !term_en)
    else $error("term on in precharge power-down");
  on_lat_a: assert property (
    $rose(term_en) && !term_wr_sel && nom_on |-> age_hi == {1'b0, lat})
    else $error("turn-on latency wrong");
  off_lat_a: assert property ($fell(term_en) && st_q.sync && !$past(term_wr_sel) && nom_on
    |-> age_lo == {1'b0, lat}) else $error("turn-off latency wrong");
  all_off_a: assert property (!nom_on && !dyn_on |=> !term_en) else $error("term on while disabled");
  hold_flag_a: assert property (early_fall_s |=> st_q.hold_err) else $error("hold violation missed");
  long_hold_a: assert property (wr_now && st_d.lvl && !chop_now |=> st_q.hold_cnt == 3'h5)
    else $error("long hold not armed");
  dyn_gate_a: assert property (!dyn_on |=> !term_wr_sel) else $error("write strength without dynamic");
  sw_on_a: assert property ($rose(term_wr_sel) |-> age_wr == {1'b0, lat})
    else $error("write strength switch latency wrong");
  ready_pulse_a: assert property (apb_o.pready |=> !apb_o.pready) else $error("pready longer than one cycle");
endmodule : dso_term_ctrl

// File: sim/dso_ctrl_model.sv
// controller-side model driving the termination request pin and write commands
`timescale 1ns/1ns
module dso_ctrl_model (
  input wire logic clk_sys,
  output logic term_req_pin,
  output logic wr_cmd,
  output logic wr_chop
);
  initial begin
    term_req_pin = 1'b0;
    wr_cmd = 1'b0;
    wr_chop = 1'b0;
  end
  // ************************************************************
  // request burst
  // ************************************************************
  // the caller picks hold and write slot; a short hold breaks the windows on purpose
  task automatic burst(input int hold, input int wr_at, input logic chop);
    for (int i = 0; i < hold; i++) begin
      @(posedge clk_sys);
      term_req_pin <= 1'b1;
      wr_cmd <= (i == wr_at);
      // burst kind is only meaningful with a write, so it wanders otherwise
      wr_chop <= (i == wr_at) ? chop : ~wr_chop;
    end
    @(posedge clk_sys);
    term_req_pin <= 1'b0;
    wr_cmd <= 1'b0;
  endtask : burst
endmodule : dso_ctrl_model

// File: sim/testbench.sv
// testbench: apb master tasks, controller model and termination timing checks
`timescale 1ns/1ns
module testbench;
  import dso_pkg::*;
  logic clk_sys, reset, term_en, term_wr_sel, pin, wr_cmd, wr_chop, err;
  logic dll_locked, cke, bank_open, seen, pin_q, en_q, ws_q;
  logic [31:0] rd;
  dso_apb_req_t apb_req;
  dso_apb_rsp_t apb_rsp;
  dso_core_in_t core;
  int mismatches, compares, cyc, t_pin, t_on, t_off, t_wr, t_ws_on, t_ws_off, d0, w0;
  assign core = '{dll_locked, cke, bank_open, wr_cmd, wr_chop};
  dso_term_ctrl #(.PIPE_D(32)) dso_term_ctrl_inst (.clk_sys(clk_sys), .reset(reset),
    .term_req_pin(pin), .core_i(core), .apb_i(apb_req), .apb_o(apb_rsp),
    .term_en(term_en), .term_wr_sel(term_wr_sel));
  dso_ctrl_model dso_ctrl_model_inst (.clk_sys(clk_sys), .term_req_pin(pin),
    .wr_cmd(wr_cmd), .wr_chop(wr_chop));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ************************************************************
  // edge monitor: only differences of these stamps are compared
  // ************************************************************
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    pin_q <= pin;
    en_q <= term_en;
    ws_q <= term_wr_sel;
    if (pin && !pin_q) t_pin <= cyc;
    if (wr_cmd) t_wr <= cyc;
    if (term_en && !en_q) t_on <= cyc;
    if (!term_en && en_q) t_off <= cyc;
    if (term_wr_sel && !ws_q) t_ws_on <= cyc;
    if (!term_wr_sel && ws_q) t_ws_off <= cyc;
    if (term_en) seen <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // request stands until the edge that samples pready high; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge clk_sys);
    apb_req <= '{1'b1, 1'b0, wr, addr, wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  function automatic logic [31:0] cfgw(int cas_write_latency, int al, int nom, int wrt, int keep);
    return (32'(cas_write_latency) << DSO_CWL_LSB) | (32'(al) << DSO_AL_LSB) | (32'(nom) << DSO_NOM_LSB)
      | (32'(wrt) << DSO_WR_LSB) | (32'(keep) << DSO_DLLPD_BIT) | (32'h1 << DSO_DLLON_BIT);
  endfunction : cfgw
  task automatic setup(input logic [31:0] c, input logic lk, input logic ck, input logic bk);
    dll_locked <= lk;
    cke <= ck;
    bank_open <= bk;
    apb(1'b1, DSO_CFG_OFS, c);
  endtask : setup
  task automatic run(input int hold, input int wr_at, input logic chop);
    @(posedge clk_sys);
    seen = 1'b0;
    dso_ctrl_model_inst.burst(hold, wr_at, chop);
    repeat (30) @(posedge clk_sys);
  endtask : run
  task automatic mode(input logic [31:0] c, input logic lk, ck, bk, ex);
    setup(c, lk, ck, bk);
    run(6, -1, 1'b0);
    chk(seen, ex);
    apb(1'b0, DSO_STAT_OFS, 32'h0);
    chk(rd[DSO_ST_SYNC_BIT], ex);
  endtask : mode
  task automatic stat(input logic ex);
    apb(1'b0, DSO_STAT_OFS, 32'h0);
    chk(rd[DSO_ST_ERR_BIT], ex);
    apb(1'b1, DSO_STAT_OFS, 32'h8);
  endtask : stat
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    final_report;
  end
  initial begin
    reset = 1'b1;
    dll_locked = 1'b1;
    cke = 1'b1;
    bank_open = 1'b0;
    seen = 1'b0;
    apb_req = '0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, DSO_CFG_OFS, 32'h0);
    chk(rd, 32'h0000_0005);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], err}, 32'h0000_0001);
    mode(cfgw(5, 0, 1, 0, 0), 1'b1, 1'b1, 1'b1, 1'b1);
    mode(cfgw(5, 0, 0, 0, 0), 1'b1, 1'b1, 1'b1, 1'b0);
    mode(cfgw(5, 0, 1, 0, 0) & ~(32'h1 << DSO_DLLON_BIT), 1'b1, 1'b1, 1'b1, 1'b0);
    mode(cfgw(5, 0, 1, 0, 0), 1'b0, 1'b1, 1'b1, 1'b0);
    mode(cfgw(5, 0, 1, 0, 0), 1'b1, 1'b0, 1'b0, 1'b0);
    mode(cfgw(5, 0, 1, 0, 0), 1'b1, 1'b0, 1'b1, 1'b1);
    mode(cfgw(5, 0, 1, 0, 1), 1'b1, 1'b0, 1'b0, 1'b1);
    setup(cfgw(5, 0, 1, 1, 0), 1'b1, 1'b1, 1'b1);
    run(8, 2, 1'b1);
    d0 = t_on - t_pin;
    w0 = t_ws_on - t_wr;
    chk(d0 >= 4 && d0 <= 8, 1);
    chk(t_off - t_on, 8);
    chk(t_ws_off - t_ws_on, 4);
    setup(cfgw(5, 2, 1, 1, 0), 1'b1, 1'b1, 1'b1);
    run(8, 2, 1'b0);
    chk(t_on - t_pin, d0 + 2);
    chk(t_off - t_on, 8);
    chk(t_ws_on - t_wr, w0 + 2);
    chk(t_ws_off - t_ws_on, 6);
    setup(cfgw(7, 0, 3, 2, 0), 1'b1, 1'b1, 1'b1);
    run(6, -1, 1'b0);
    chk(t_on - t_pin, d0 + 2);
    stat(1'b0);
    run(2, -1, 1'b0);
    stat(1'b1);
    stat(1'b0);
    run(5, 1, 1'b0);
    stat(1'b1);
    run(5, 2, 1'b1);
    stat(1'b1);
    final_report;
  end
endmodule : testbench
